// File: rtl/css_i2c_if.sv
`timescale 1ns/10ps
interface css_i2c_if;
  logic       scl;
  logic       sda;
  logic       busy;
  logic [7:0] tx_byte;
  logic       sda_oe;
  logic [7:0] rx_byte;
  logic       rx_valid;
  modport slave (input scl, sda, busy, tx_byte, output sda_oe, rx_byte, rx_valid);
  modport core  (output scl, sda, busy, tx_byte, input sda_oe, rx_byte, rx_valid);
endinterface

// File: rtl/css_i2c_slave.sv
`timescale 1ns/10ps
module css_i2c_slave
  import css_pkg::*;
(
  input  wire logic clk,     // System clock
  input  wire logic reset,   // Synchronous reset
  css_i2c_if.slave  bus      // Synchronised lines and byte port
);
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_MACK} css_i2c_state_type;
  css_i2c_state_type state;
  logic       scl_q, sda_q, rw, nack;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       rise, fall, start, stop;

  assign rise  = bus.scl & ~scl_q;
  assign fall  = ~bus.scl & scl_q;
  assign start = bus.scl & scl_q & sda_q & ~bus.sda;
  assign stop  = bus.scl & scl_q & ~sda_q & bus.sda;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  always_ff @(posedge clk)
  begin
    bus.rx_valid <= 1'b0;
    if (reset)
    begin
      state <= I_IDLE;
      bus.sda_oe <= 1'b0;
      bus.rx_byte <= 8'h00;
      sh <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      nack <= 1'b0;
    end
    else if (stop)
    begin
      state <= I_IDLE;
      bus.sda_oe <= 1'b0;
    end
    else if (start)
    begin
      state <= I_ADDR;
      cnt <= 4'h0;
      bus.sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        I_ADDR, I_RX:
        begin
          if (rise && cnt != 4'd8)
          begin
            sh <= {sh[6:0], bus.sda};
            cnt <= cnt + 4'd1;
          end
          else if (fall && cnt == 4'd8)
          begin
            if (state == I_RX)
            begin
              bus.rx_byte <= sh;
              bus.rx_valid <= 1'b1;
              bus.sda_oe <= 1'b1;
              state <= I_ACK;
            end
            else if (sh[7:1] == I2C_ADDR && !bus.busy)
            begin
              rw <= sh[0];
              bus.sda_oe <= 1'b1;
              state <= I_ACK;
            end
            else
              state <= I_IDLE;
          end
        end
        I_ACK:
        begin
          if (fall)
          begin
            cnt <= 4'd1;
            if (rw)
            begin
              bus.sda_oe <= ~bus.tx_byte[7];
              sh <= {bus.tx_byte[6:0], 1'b0};
              state <= I_TX;
            end
            else
            begin
              bus.sda_oe <= 1'b0;
              cnt <= 4'd0;
              state <= I_RX;
            end
          end
        end
        I_TX:
        begin
          if (fall)
          begin
            if (cnt == 4'd8)
            begin
              bus.sda_oe <= 1'b0;
              state <= I_MACK;
            end
            else
            begin
              bus.sda_oe <= ~sh[7];
              sh <= {sh[6:0], 1'b0};
              cnt <= cnt + 4'd1;
            end
          end
        end
        I_MACK:
        begin
          if (rise)
            nack <= bus.sda;
          else if (fall)
          begin
            state <= nack ? I_IDLE : I_ACK;
            bus.sda_oe <= 1'b0;
          end
        end
        default:
          bus.sda_oe <= 1'b0;
      endcase
    end
  end
endmodule

// File: rtl/css_pkg.sv
package css_pkg;
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          CLK_KHZ        = CLK_HZ / 1000;
  localparam int          NUM_CH         = 4;
  localparam int          COUNT_W        = 12;
  localparam logic [6:0]  I2C_ADDR       = 7'h44;
  // Slot and low-power timing
  localparam int          SLOT_TIME_US   = 2600;
  localparam int          SLOT_CYC_DEF   = SLOT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          LP_TICK_MS     = 16;
  localparam int          LP_TICK_DEF    = LP_TICK_MS * CLK_KHZ;
  localparam logic [7:0]  LP_FIRST_MULT  = 8'h03;
  localparam int          DISCH_TIME_NS  = 2000;
  localparam int          DISCH_CYC      = (DISCH_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Charge transfer frequencies and clock divisors (shortest period rounds down)
  localparam int          FREQ_SELF_KHZ  = 500;
  localparam int          FREQ_PROJ_KHZ  = 1000;
  localparam logic [7:0]  DIV_SELF       = 8'(CLK_KHZ / FREQ_SELF_KHZ);
  localparam logic [7:0]  DIV_SELF_X2    = 8'(CLK_KHZ / (2 * FREQ_SELF_KHZ));
  localparam logic [7:0]  DIV_PROJ       = 8'(CLK_KHZ / FREQ_PROJ_KHZ);
  localparam logic [7:0]  DIV_PROJ_X2    = 8'(CLK_KHZ / (2 * FREQ_PROJ_KHZ));
  // Register byte offsets
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_OPTION0    = 8'h04;
  localparam logic [7:0]  OFS_LP_INT     = 8'h08;
  localparam logic [7:0]  OFS_THRESH     = 8'h0c;
  localparam logic [7:0]  OFS_SYSTEM_FLAGS   = 8'h10;
  localparam logic [7:0]  OFS_EVENTS     = 8'h14;
  localparam logic [7:0]  OFS_RESULT     = 8'h18;
  localparam logic [7:0]  OFS_MAILBOX    = 8'h1c;
  // Field positions, reset values and average shift
  localparam int          CTL_FREQ_X2    = 0;
  localparam int          CTL_CH3_EN     = 1;
  localparam int          CTL_CH1_EN     = 2;
  localparam int          CTL_CH2_EN     = 3;
  localparam int          CTL_FLOAT      = 4;
  localparam int          OPT0_PROJ      = 3;
  localparam logic [4:0]  CTL_RESET      = 5'b0_1100;
  localparam logic [11:0] PROX_TH_RESET  = 12'h0_008;
  localparam logic [11:0] TOUCH_TH_RESET = 12'h0_010;
  localparam int          LTA_SHIFT      = 4;
endpackage

// File: rtl/css_result_mem.sv
`timescale 1ns/10ps
module css_result_mem
  import css_pkg::*;
(
  input  wire logic                 clk,    // System clock
  input  wire logic                 we,     // Write strobe
  input  wire logic [1:0]           waddr,  // Write channel
  input  wire logic [2*COUNT_W-1:0] wdata,  // Count and average
  input  wire logic [1:0]           raddr,  // Read channel
  output logic      [2*COUNT_W-1:0] rdata   // Registered read data
);
  logic [2*COUNT_W-1:0] mem [NUM_CH];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end
endmodule

// File: rtl/css_scheduler.sv
// Operation
// - Slave only, answers address 44h alone
// - Ready line low idle, high converting
// - Address not acknowledged while line high
// - Four channels measured in separate slots
// - Discharge, charge, transfer until trip voltage
// - Twelve-bit count compared with twelve-bit average
// - Default 1 MHz projected, 500 kHz self
// - Frequency doubled when doubling bit set
// - Normal power: 2.6 ms slot each
// - Disabled channel slot is skipped
// - Low-power interval is value times 16 ms, except 02h: also 16 ms
// - Proximity event in low power zooms in
// - Zoomed: active channels back to back
// - Low-power flag when rate set, not zoomed
// - Channels one, two default; third by enable
// - Low power measures proximity channel only
// - Self default; option bit three selects projected
// - Event when count crosses average by threshold
`timescale 1ns/10ps
module css_scheduler
  import css_pkg::*;
#(
  parameter int SLOT_CYCLES    = SLOT_CYC_DEF,  // One measurement slot
  parameter int LP_TICK_CYCLES = LP_TICK_DEF,   // Low-power interval unit
  parameter int LP_ONE_CYCLES  = LP_TICK_DEF,   // Interval for value 01h
  parameter int LP_TWO_CYCLES  = LP_TICK_DEF    // Interval for value 02h
)
(
  input  wire logic              clk,              // 25 MHz clock
  input  wire logic              reset,            // Synchronous, active high
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB enable
  input  wire logic              pwrite,           // APB direction
  input  wire logic [7:0]        paddr,            // APB byte address
  input  wire logic [31:0]       pwdata,           // APB write data
  output logic      [31:0]       prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB error, unmapped or read-only write
  input  wire logic              scl_in,           // Bus clock pin level
  input  wire logic              sda_in,           // Bus data pin level
  output logic                   sda_out,          // Bus data drive value
  output logic                   sda_oe,           // Bus data drive enable
  output logic                   ready_request_n,  // Low when ready to talk
  input  wire logic              trip_in,          // Trip comparator pin
  output logic                   cs_discharge,     // Discharge sampling cap
  output logic                   transfer_pulse,   // One charge transfer
  output logic      [NUM_CH-1:0] elec_charge,      // Electrode charge drive
  output logic      [NUM_CH-1:0] elec_ground       // Electrode grounding
);
  typedef enum logic [2:0] {S_IDLE, S_DISCH, S_CHARGE, S_XFER, S_COMPUTE, S_UPDATE, S_PAD, S_LPWAIT}
    css_state_type;
  css_state_type state;

  css_i2c_if i2c ();

  logic [1:0]         scl_s, sda_s, trip_s;
  logic [4:0]         control;
  logic [7:0]         option0, lp_interval, mailbox;
  logic [11:0]        prox_th, touch_th;
  logic [NUM_CH-1:0]  events, seeded;
  logic [1:0]         ch;
  logic               zoom, prox_seen, busy, low_power_active_flag;
  logic [16:0]        slot_cnt;
  logic [31:0]        lp_cnt, lp_limit;
  logic [7:0]         div_cnt, div_max;
  logic               chg_tick;
  logic [COUNT_W-1:0] count, last_count, last_lta, threshold;
  logic [2*COUNT_W-1:0] mem_rdata;
  logic [COUNT_W-1:0] long_term_average, next_lta;
  logic               hit;
  logic [NUM_CH-1:0]  active;
  logic [2:0]         nxt;
  logic               lp_sel, projected;
  logic [31:0]        rd_value;
  logic               rd_ok;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      scl_s  <= 2'b11;
      sda_s  <= 2'b11;
      trip_s <= 2'b00;
    end
    else
    begin
      scl_s  <= {scl_s[0], scl_in};
      sda_s  <= {sda_s[0], sda_in};
      trip_s <= {trip_s[0], trip_in};
    end
  end

  assign i2c.scl     = scl_s[1];
  assign i2c.sda     = sda_s[1];
  assign i2c.busy    = busy;
  assign i2c.tx_byte = {4'h0, busy, zoom, projected, low_power_active_flag};

  css_i2c_slave u_i2c (
    .clk   (clk),
    .reset (reset),
    .bus   (i2c.slave)
  );

  // Open-drain data line only ever pulls low
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
    sda_oe  <= reset ? 1'b0 : i2c.sda_oe;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mailbox <= 8'h00;
    else if (i2c.rx_valid)
      mailbox <= i2c.rx_byte;
  end

  assign projected = option0[OPT0_PROJ];
  assign lp_sel    = lp_interval != 8'h00;

  assign active = (lp_sel && !zoom) ? 4'b0001
                : {control[CTL_CH3_EN], control[CTL_CH2_EN], control[CTL_CH1_EN], 1'b1};

  always_comb
  begin
    nxt = 3'd4;
    for (int i = NUM_CH - 1; i > 0; i--)
      if (active[i] && 3'(i) > {1'b0, ch})
        nxt = 3'(i);
  end

  always_comb
  begin
    if (projected)
      div_max = control[CTL_FREQ_X2] ? DIV_PROJ_X2 : DIV_PROJ;
    else
      div_max = control[CTL_FREQ_X2] ? DIV_SELF_X2 : DIV_SELF;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state == S_IDLE || div_cnt == div_max - 8'd1)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'd1;
  end
  assign chg_tick = div_cnt == div_max - 8'd1;

  always_comb
  begin
    case (lp_interval)
      8'h01:   lp_limit = LP_ONE_CYCLES;
      8'h02:   lp_limit = LP_TWO_CYCLES;
      default: lp_limit = 32'(lp_interval * LP_TICK_CYCLES);
    endcase
  end

  assign long_term_average       = mem_rdata[COUNT_W-1:0];
  assign threshold = (ch == 2'd0) ? prox_th : touch_th;
  assign hit = !seeded[ch] ? 1'b0
             : projected ? ({1'b0, count} > {1'b0, long_term_average} + {1'b0, threshold})
             : ({1'b0, count} + {1'b0, threshold} < {1'b0, long_term_average});

  // Average tracks slowly and freezes while an event stands
  always_comb
  begin
    if (!seeded[ch])
      next_lta = count;
    else if (hit)
      next_lta = long_term_average;
    else
      next_lta = COUNT_W'($signed({1'b0, long_term_average}) + ($signed({1'b0, count} - {1'b0, long_term_average}) >>> LTA_SHIFT));
  end

  css_result_mem u_mem (
    .clk   (clk),
    .we    (state == S_UPDATE),
    .waddr (ch),
    .wdata ({count, next_lta}),
    .raddr (ch),
    .rdata (mem_rdata)
  );

  // Slot sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state    <= S_IDLE;
      ch       <= 2'd0;
      count    <= '0;
      slot_cnt <= '0;
      lp_cnt   <= '0;
    end
    else
    begin
      slot_cnt <= slot_cnt + 17'd1;
      lp_cnt   <= lp_cnt + 32'd1;
      case (state)
        S_IDLE:
        begin
          // One slot per channel
          // Setup cycle is the slot's first cycle, so a slot is exactly SLOT_CYCLES
          slot_cnt <= 17'd1;
          count    <= '0;
          if (ch == 2'd0)
            lp_cnt <= 32'd1;
          state    <= S_DISCH;
        end
        S_DISCH:
          if (slot_cnt == 17'(DISCH_CYC))
            state <= S_CHARGE;
        S_CHARGE:
          if (chg_tick)
            state <= S_XFER;
        S_XFER:
          // Transfers until trip or full scale
          if (trip_s[1] || &count)
            state <= S_COMPUTE;
          else if (chg_tick)
            count <= count + 12'd1;
        S_COMPUTE:
          state <= S_UPDATE;
        S_UPDATE:
          state <= S_PAD;
        S_PAD:
          if (slot_cnt >= 17'(SLOT_CYCLES - 1))
          begin
            if (nxt != 3'd4)
            begin
              ch    <= nxt[1:0];
              state <= S_IDLE;
            end
            else
            begin
              ch     <= 2'd0;
              state  <= (lp_sel && !zoom) ? S_LPWAIT : S_IDLE;
            end
          end
        S_LPWAIT:
        begin
          // A round longer than the interval simply starts the next one at once
          if (!lp_sel || lp_cnt >= lp_limit - 32'd1)
            state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // Busy from slot start until results stored
  always_ff @(posedge clk)
  begin
    if (reset)
      busy <= 1'b0;
    else if (state == S_IDLE)
      busy <= 1'b1;
    else if (state == S_UPDATE)
      busy <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ready_request_n <= 1'b0;
    else
      ready_request_n <= busy || state == S_IDLE;
  end

  // Results, events and zoom
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      events     <= '0;
      seeded     <= '0;
      zoom       <= 1'b0;
      prox_seen  <= 1'b0;
      last_count <= '0;
      last_lta   <= '0;
    end
    else if (state == S_UPDATE)
    begin
      events[ch] <= hit;
      seeded[ch] <= 1'b1;
      last_count <= count;
      last_lta   <= next_lta;
      if (ch == 2'd0)
      begin
        prox_seen <= hit;
        if (hit && lp_sel)
          zoom <= 1'b1;
      end
    end
    else if (state == S_PAD && nxt == 3'd4 && slot_cnt >= 17'(SLOT_CYCLES - 1))
    begin
      if (!prox_seen || !lp_sel)
        zoom <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      low_power_active_flag <= 1'b0;
    else
      low_power_active_flag <= lp_sel && !zoom;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_elec
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          elec_charge[g] <= 1'b0;
          elec_ground[g] <= 1'b0;
        end
        else
        begin
          elec_charge[g] <= (ch == 2'(g)) && state == S_CHARGE;
          elec_ground[g] <= (ch == 2'(g)) ? state == S_DISCH : !control[CTL_FLOAT];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cs_discharge   <= 1'b0;
      transfer_pulse <= 1'b0;
    end
    else
    begin
      cs_discharge   <= state == S_DISCH;
      transfer_pulse <= state == S_XFER && chg_tick && !trip_s[1] && !(&count);
    end
  end

  // APB register map
  always_comb
  begin
    rd_ok    = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      OFS_CONTROL:  rd_value = {27'h0, control};
      OFS_OPTION0:  rd_value = {24'h0, option0};
      OFS_LP_INT:   rd_value = {24'h0, lp_interval};
      OFS_THRESH:   rd_value = {4'h0, touch_th, 4'h0, prox_th};
      OFS_SYSTEM_FLAGS: rd_value = {28'h0, busy, zoom, projected, low_power_active_flag};
      OFS_EVENTS:   rd_value = {28'h0, events};
      OFS_RESULT:   rd_value = {2'b00, ch, last_lta, 4'h0, last_count};
      OFS_MAILBOX:  rd_value = {24'h0, mailbox};
      default:      rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_value;
        pslverr <= !rd_ok || (pwrite && (paddr == OFS_SYSTEM_FLAGS || paddr == OFS_EVENTS || paddr == OFS_RESULT));
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control     <= CTL_RESET;
      option0     <= 8'h00;
      lp_interval <= 8'h00;
      prox_th     <= PROX_TH_RESET;
      touch_th    <= TOUCH_TH_RESET;
    end
    else if (psel && penable && pready && pwrite)
    begin
      case (paddr)
        OFS_CONTROL: control     <= pwdata[4:0];
        OFS_OPTION0: option0     <= pwdata[7:0];
        OFS_LP_INT:  lp_interval <= pwdata[7:0];
        OFS_THRESH:
        begin
          prox_th  <= pwdata[11:0];
          touch_th <= pwdata[27:16];
        end
        default: ;
      endcase
    end
  end
endmodule

// File: verif/css_host_model.sv
`timescale 1ns/10ps
module css_host_model (
  input  wire logic clk,              // System clock
  input  wire logic ready_request_n,  // Device ready line
  input  wire logic dev_oe,           // Device pulls data low
  output logic      scl,              // Bus clock wire
  output logic      sda               // Bus data wire
);
  logic scl_low;
  logic sda_low;
  // Pull-ups: a released wire reads high, and the clock stands still between frames
  assign scl = !scl_low;
  assign sda = !(sda_low || dev_oe);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic probe(input logic [6:0] addr, input logic wait_rdy, output logic ack);
    logic [8:0] bits;
    bits = {addr, 2'b01};
    // Start as a ready window opens
    // The address is then checked well before the next slot goes busy
    while (wait_rdy && !ready_request_n) @(posedge clk);
    while (wait_rdy && ready_request_n) @(posedge clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 8; i >= 0; i--)
    begin
      scl_low <= 1'b1;
      repeat (3) @(posedge clk);
      sda_low <= !bits[i];
      repeat (3) @(posedge clk);
      scl_low <= 1'b0;
      repeat (4) @(posedge clk);
    end
    ack = !sda;
    scl_low <= 1'b1;
    repeat (3) @(posedge clk);
    sda_low <= 1'b1;
    repeat (3) @(posedge clk);
    scl_low <= 1'b0;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// File: verif/css_monitor.sv
`timescale 1ns/10ps
module css_monitor
  import css_pkg::*;
(
  input wire logic              clk,              // System clock
  input wire logic              reset,            // Synchronous reset
  input wire logic              sda_out,          // Data drive value
  input wire logic              sda_oe,           // Data drive enable
  input wire logic              ready_request_n,  // Low when free
  input wire logic              cs_discharge,     // Discharge phase
  input wire logic              transfer_pulse,   // Transfer strobe
  input wire logic [NUM_CH-1:0] elec_charge,      // Charge drive
  input wire logic [NUM_CH-1:0] elec_ground       // Grounding
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_drive_low_only: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_busy_discharge: assert property (cs_discharge |-> ready_request_n)
    else $error("ready low during discharge");
  a_busy_transfer: assert property (transfer_pulse |-> ready_request_n)
    else $error("ready low during transfers");
  a_one_channel: assert property ($onehot0(elec_charge))
    else $error("two channels charged at once");
  a_charged_floats: assert property ((elec_charge & elec_ground) == '0)
    else $error("channel charged and grounded");
  a_discharge_idle: assert property (cs_discharge |-> elec_charge == '0 && elec_ground != '0)
    else $error("charge drive during discharge");
  a_discharge_hold: assert property ($rose(cs_discharge) |-> cs_discharge [*8])
    else $error("discharge phase too short");
  a_pulse_single: assert property (transfer_pulse |=> !transfer_pulse && !cs_discharge)
    else $error("transfer pulse too long");
endmodule

bind css_scheduler css_monitor mon_u (.clk(clk), .reset(reset), .sda_out(sda_out), .sda_oe(sda_oe),
  .ready_request_n(ready_request_n), .cs_discharge(cs_discharge), .transfer_pulse(transfer_pulse),
  .elec_charge(elec_charge), .elec_ground(elec_ground));

// File: verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb_top
  import css_pkg::*;
();
  localparam int SLOT = 600;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sda_out;
  logic        sda_oe;
  logic        ready_request_n;
  logic        trip_in;
  logic        cs_discharge;
  logic        transfer_pulse;
  logic [3:0]  elec_charge;
  logic [3:0]  elec_ground;
  wire         scl;
  wire         sda;
  logic [3:0]  seen;
  logic        clr;
  logic        ch0_q;
  logic [31:0] rd;
  logic        err;
  logic        ack;
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          n_pulse;
  int          trips;
  int          rise_at;
  int          gap;
  int          last_p;
  int          pp;
  css_scheduler #(.SLOT_CYCLES(SLOT), .LP_TICK_CYCLES(500), .LP_ONE_CYCLES(300), .LP_TWO_CYCLES(300)) dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .ready_request_n(ready_request_n), .trip_in(trip_in),
    .cs_discharge(cs_discharge), .transfer_pulse(transfer_pulse), .elec_charge(elec_charge),
    .elec_ground(elec_ground));
  css_host_model host_u (.clk(clk), .ready_request_n(ready_request_n), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Electrode stand-in: trips after a set number of transfers
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    seen <= clr ? 4'h0 : (seen | elec_charge);
    n_pulse <= cs_discharge ? 0 : n_pulse + int'(transfer_pulse);
    trip_in <= !cs_discharge && n_pulse >= trips;
    ch0_q <= elec_charge[0];
    if (elec_charge[0] && !ch0_q)
    begin
      gap <= cyc - rise_at;
      rise_at <= cyc;
    end
    if (transfer_pulse)
    begin
      // First pulse of a slot would measure the gap between slots
      if (n_pulse != 0)
        pp <= cyc - last_p;
      last_p <= cyc;
    end
    if (cyc == 60000)
    begin
      n_fail++;
      close_out;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_seen(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    {reset, clr, trip_in, ch0_q} = 4'b1000;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, num_checks, cyc, n_pulse, rise_at, gap, last_p, pp, seen} = '0;
    trips = 3;
    repeat (11) @(posedge clk);
    @(negedge clk);
    `CHK(ready_request_n, 1'b0)
    @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(ready_request_n, 1'b1)
    apb(1'b0, OFS_CONTROL, 32'h0);
    `CHK(rd, 32'h0000_000c)
    apb(1'b0, OFS_THRESH, 32'h0);
    `CHK(rd, {4'h0, TOUCH_TH_RESET, 4'h0, PROX_TH_RESET})
    apb(1'b0, OFS_SYSTEM_FLAGS, 32'h0);
    `CHK(rd[2:0], 3'b000)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, OFS_SYSTEM_FLAGS, 32'h0000_000f);
    `CHK(err, 1'b1)
    $display("test registers done");
    wait_seen(4 * SLOT);
    `CHK(seen, 4'b0111)
    `CHK(pp, 50)
    apb(1'b0, OFS_RESULT, 32'h0);
    `CHK(rd[11:0], 12'h003)
    `CHK(rd[27:16], 12'h003)
    apb(1'b1, OFS_CONTROL, 32'h0000_000e);
    wait_seen(9 * SLOT);
    `CHK(seen, 4'b1111)
    `CHK(gap, 4 * SLOT)
    apb(1'b1, OFS_CONTROL, 32'h0000_000a);
    repeat (SLOT) @(posedge clk);
    wait_seen(7 * SLOT);
    `CHK(seen, 4'b1101)
    `CHK(gap, 3 * SLOT)
    $display("test slots done");
    host_u.probe(I2C_ADDR, 1'b1, ack);
    `CHK(ack, 1'b1)
    host_u.probe(7'h45, 1'b1, ack);
    `CHK(ack, 1'b0)
    while (!ready_request_n) @(posedge clk);
    host_u.probe(I2C_ADDR, 1'b0, ack);
    `CHK(ack, 1'b0)
    $display("test address done");
    apb(1'b1, OFS_LP_INT, 32'h0000_0003);
    repeat (4 * SLOT) @(posedge clk);
    apb(1'b0, OFS_SYSTEM_FLAGS, 32'h0);
    `CHK(rd[0], 1'b1)
    wait_seen(4000);
    `CHK(seen, 4'b0001)
    `CHK(gap, 3 * 500)
    apb(1'b1, OFS_OPTION0, 32'h0000_0008);
    trips <= 15;
    repeat (4000) @(posedge clk);
    apb(1'b0, OFS_SYSTEM_FLAGS, 32'h0);
    `CHK(rd[2:0], 3'b110)
    `CHK(pp, 25)
    apb(1'b1, OFS_CONTROL, 32'h0000_000b);
    repeat (4 * SLOT) @(posedge clk);
    `CHK(pp, 12)
    $display("test low power done");
    close_out;
  end
endmodule
